// ### iqso_defs.svh
/*
  Constants for the I/Q serial output port: register offsets, control
  field positions, reset values and frame content sizes.
  Assumes it is included by bare name from the package and the design.
*/
`ifndef IQSO_DEFS_SVH
`define IQSO_DEFS_SVH

// Register offsets on the 6-bit register port
`define IQSO_ADDR_W          6
`define IQSO_ADDR_FMT        6'h18
`define IQSO_ADDR_WIDTH      6'h19
`define IQSO_ADDR_DIV        6'h1a

// Reset values
`define IQSO_FMT_RST         8'h12
`define IQSO_WIDTH_RST       8'h07
`define IQSO_DIV_RST         4'h1

// Format control fields
`define IQSO_FMT_ALT         7
`define IQSO_FMT_EMBED       6
`define IQSO_FMT_EFS         5
`define IQSO_FMT_SYNC_TRI    4
`define IQSO_FMT_SYNC_INV    3
`define IQSO_FMT_LATE        2
`define IQSO_FMT_BCLK_TRI    1
`define IQSO_FMT_BCLK_INV    0

// Width and drive control fields
`define IQSO_WID_SPI4        7
`define IQSO_WID_DW          3

// Frame content bit counts
`define IQSO_BITS_WORD16     7'd16
`define IQSO_BITS_WORD24     7'd24
`define IQSO_BITS_GAIN_BOTH  7'd16
`define IQSO_BITS_GAIN_ALT   7'd8
`define IQSO_SHIFT_W         64
`define IQSO_EFS_LAST_PH     4'd9
`define IQSO_RST_CNT_MAX     2'd3

`endif

// ### iqso_pkg.sv
/*
  Types for the I/Q serial output port.
  Assumes iqso_defs.svh is on the include path.
*/
`include "iqso_defs.svh"

package iqso_pkg;

  // Bit sequencer states, one-hot
  typedef enum logic [2:0] {
    IQSO_IDLE = 3'b001,
    IQSO_SYNC = 3'b010,
    IQSO_DATA = 3'b100
  } iqso_state_t;

  // One decimated sample with its gain and status side data
  typedef struct packed {
    logic [23:0] i_word;
    logic [23:0] q_word;
    logic [7:0]  atten;
    logic [5:0]  rssi;
  } iqso_sample_t;

  // Output pins; enables are active low
  typedef struct packed {
    logic frame_sync_out;
    logic frame_sync_oe_n;
    logic bit_clock_out;
    logic bit_clock_oe_n;
    logic serial_data_out;
  } iqso_pins_t;

endpackage

// ### iqso_port.sv
/*
  I/Q serial output port: frames each decimated sample into a serial
  stream with a divided bit clock and a dedicated or embedded frame sync.
  Assumes one modulator clock domain, a one-cycle sample strobe from the
  decimator, and a plain register port driven synchronously.
*/
`timescale 1ns/100ps
`default_nettype none
`include "iqso_defs.svh"

module iqso_port (
  // Clock and reset
  input  wire logic                     i_clock,
  input  wire logic                     i_rst_n,
  // Register port
  input  wire logic [`IQSO_ADDR_W-1:0]  i_reg_addr,
  input  wire logic [7:0]               i_reg_wdata,
  input  wire logic                     i_reg_wr,
  input  wire logic                     i_reg_rd,
  output logic      [7:0]               o_reg_rdata,
  // Decimated sample stream
  input  wire logic                     i_sample_stb,
  input  wire iqso_pkg::iqso_sample_t   i_sample,
  input  wire logic                     i_mod_reset_evt,
  // Serial pins
  output iqso_pkg::iqso_pins_t          o_pins
);
  import iqso_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0] fmt_r;
  logic [7:0] width_r;
  logic [3:0] div_r;

  // Software writes; unmapped offsets are ignored
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fmt_r   <= `IQSO_FMT_RST;
      width_r <= `IQSO_WIDTH_RST;
      div_r   <= `IQSO_DIV_RST;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        `IQSO_ADDR_FMT:   fmt_r   <= i_reg_wdata;
        `IQSO_ADDR_WIDTH: width_r <= i_reg_wdata;
        `IQSO_ADDR_DIV:   div_r   <= i_reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        `IQSO_ADDR_FMT:   o_reg_rdata <= fmt_r;
        `IQSO_ADDR_WIDTH: o_reg_rdata <= width_r;
        `IQSO_ADDR_DIV:   o_reg_rdata <= {4'h0, div_r};
        default:          o_reg_rdata <= 8'h00;
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // Decoded controls
  logic alt_mode;
  logic embed_gain;
  logic embedded_framing;
  logic late_sync;
  logic word24;
  assign alt_mode   = fmt_r[`IQSO_FMT_ALT];
  assign embed_gain = fmt_r[`IQSO_FMT_EMBED];
  assign embedded_framing        = fmt_r[`IQSO_FMT_EFS];
  assign late_sync  = fmt_r[`IQSO_FMT_LATE] & ~embedded_framing;
  assign word24     = width_r[`IQSO_WID_DW];

  //////////////////////////////////////////////////////////////////////////
  // Frame content

  // Number of content bits for the current format
  function automatic logic [6:0] content_bits(input logic w24, input logic eg,
                                              input logic alt);
    logic [6:0] n;
    n = w24 ? `IQSO_BITS_WORD24 : `IQSO_BITS_WORD16;
    n = 7'(n + n);
    if (eg) begin
      n = 7'(n + (alt ? `IQSO_BITS_GAIN_ALT : `IQSO_BITS_GAIN_BOTH));
    end
    return n;
  endfunction

  // Saturating count of modulator resets since the last report
  logic [1:0] rst_cnt_r;
  logic       report_status;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_cnt_r <= 2'd0;
    end else if (report_status) begin
      // An event in the reporting cycle is kept for the next report
      rst_cnt_r <= i_mod_reset_evt ? 2'd1 : 2'd0;
    end else if (i_mod_reset_evt && rst_cnt_r != `IQSO_RST_CNT_MAX) begin
      rst_cnt_r <= 2'(rst_cnt_r + 2'd1);
    end
  end

  // Alternating byte select, flips after each frame that carries one
  logic alt_sel_r;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alt_sel_r <= 1'b0;
    end else if (i_sample_stb && embed_gain && alt_mode) begin
      alt_sel_r <= ~alt_sel_r;
    end
  end

  // Status byte reported this frame when both bytes or the status turn
  assign report_status = i_sample_stb && embed_gain && (!alt_mode || alt_sel_r);

  // Left-justified content image, MSB first
  logic [7:0]               stat_byte;
  logic [15:0]              gain_word;
  logic [47:0]              iq_bits;
  logic [`IQSO_SHIFT_W-1:0] image;
  always_comb begin
    stat_byte = {rst_cnt_r, i_sample.rssi};
    image     = '0;
    if (word24) begin
      iq_bits = {i_sample.i_word, i_sample.q_word};
    end else begin
      iq_bits = {i_sample.i_word[23:8], i_sample.q_word[23:8], 16'h0000};
    end
    if (!embed_gain) begin
      gain_word = 16'h0000;
    end else if (!alt_mode) begin
      gain_word = {i_sample.atten, stat_byte};
    end else if (alt_sel_r) begin
      gain_word = {stat_byte[7:1], 1'b1, 8'h00};
    end else begin
      gain_word = {i_sample.atten[7:1], 1'b0, 8'h00};
    end
    // Gain bits sit right after the Q word
    if (word24) begin
      image = {iq_bits, gain_word};
    end else begin
      image = {iq_bits[47:16], gain_word, 16'h0000};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bit clock divider

  logic [3:0] div_cnt_r;
  logic [3:0] div_last;
  logic [3:0] div_half;
  logic       bit_adv;

  // Divisor zero behaves as one
  assign div_last = (div_r == 4'h0) ? 4'h0 : 4'(div_r - 4'h1);
  // Widened before the add so a divisor of 15 does not wrap to a dead clock
  assign div_half = 4'(({1'b0, div_last} + 5'h02) >> 1);
  assign bit_adv  = (div_cnt_r == div_last);

  // Restarted by each frame so bit edges line up with the sync
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt_r <= 4'h0;
    end else if (i_sample_stb || bit_adv) begin
      div_cnt_r <= 4'h0;
    end else begin
      div_cnt_r <= 4'(div_cnt_r + 4'h1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bit sequencer

  iqso_state_t              state_r;
  logic [`IQSO_SHIFT_W-1:0] shift_r;
  logic [6:0]               rem_r;
  logic [3:0]               ph_r;
  logic                     first_r;

  // One frame per sample strobe; strobe wins over any bit in flight
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= IQSO_IDLE;
      shift_r <= '0;
      rem_r   <= 7'd0;
      ph_r    <= 4'd0;
      first_r <= 1'b0;
    end else if (i_sample_stb) begin
      shift_r <= image;
      rem_r   <= content_bits(word24, embed_gain, alt_mode);
      ph_r    <= 4'd0;
      first_r <= 1'b1;
      // Early sync spends one bit before the data
      state_r <= (embedded_framing || late_sync) ? IQSO_DATA : IQSO_SYNC;
    end else if (bit_adv) begin
      unique case (state_r)
        IQSO_IDLE: ;
        IQSO_SYNC: begin
          state_r <= IQSO_DATA;
          first_r <= 1'b0;
        end
        IQSO_DATA: begin
          first_r <= 1'b0;
          if (!embedded_framing) begin
            shift_r <= {shift_r[`IQSO_SHIFT_W-2:0], 1'b0};
            rem_r   <= 7'(rem_r - 7'd1);
            if (rem_r == 7'd1) begin
              state_r <= IQSO_IDLE;
            end
          end else if (ph_r == 4'd0) begin
            ph_r <= 4'd1;
          end else if (ph_r == `IQSO_EFS_LAST_PH) begin
            ph_r <= 4'd0;
            if (rem_r == 7'd0) begin
              state_r <= IQSO_IDLE;
            end
          end else begin
            shift_r <= {shift_r[`IQSO_SHIFT_W-2:0], 1'b0};
            rem_r   <= 7'(rem_r - 7'd1);
            ph_r    <= 4'(ph_r + 4'd1);
          end
        end
      endcase
    end
  end

  // Current line levels, before the output flops
  logic cur_data;
  logic cur_sync;
  always_comb begin
    cur_data = 1'b1;
    if (state_r == IQSO_DATA) begin
      if (!embedded_framing) begin
        cur_data = shift_r[`IQSO_SHIFT_W-1];
      end else if (ph_r == 4'd0) begin
        cur_data = 1'b0;
      end else if (ph_r == `IQSO_EFS_LAST_PH) begin
        cur_data = 1'b1;
      end else begin
        cur_data = shift_r[`IQSO_SHIFT_W-1];
      end
    end
    // Pulse one bit long: before the data, or on the first data bit
    cur_sync = (state_r == IQSO_SYNC) ||
               (state_r == IQSO_DATA && first_r && late_sync);
  end

  //////////////////////////////////////////////////////////////////////////
  // Output pins

  // All pins registered together so data, clock and sync stay aligned
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pins <= '{frame_sync_out: 1'b0, frame_sync_oe_n: 1'b1,
                  bit_clock_out: 1'b1, bit_clock_oe_n: 1'b1,
                  serial_data_out: 1'b1};
    end else begin
      o_pins.serial_data_out <= cur_data;
      // Rising edge starts each bit; divisor one holds the clock high
      o_pins.bit_clock_out   <= (div_cnt_r < div_half) ^
                                fmt_r[`IQSO_FMT_BCLK_INV];
      o_pins.bit_clock_oe_n  <= fmt_r[`IQSO_FMT_BCLK_TRI];
      o_pins.frame_sync_oe_n <= fmt_r[`IQSO_FMT_SYNC_TRI];
      if (embedded_framing) begin
        o_pins.frame_sync_out <= 1'b0;
      end else begin
        o_pins.frame_sync_out <= cur_sync ^
                                 fmt_r[`IQSO_FMT_SYNC_INV];
      end
    end
  end

endmodule
`default_nettype wire

// ### iqso_port_properties.sv
/*
  Checker for iqso_port: register read-back and pin timing per frame.
  Assumes binding to iqso_port; the format and divisor registers are shadowed from writes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "iqso_defs.svh"

module iqso_port_properties (
  // Clock, reset and register port
  input wire logic                    i_clock,
  input wire logic                    i_rst_n,
  input wire logic [`IQSO_ADDR_W-1:0] i_reg_addr,
  input wire logic [7:0]              i_reg_wdata,
  input wire logic                    i_reg_wr,
  input wire logic                    i_reg_rd,
  input wire logic [7:0]              o_reg_rdata,
  // Sample stream and pins
  input wire logic                    i_sample_stb,
  input wire iqso_pkg::iqso_sample_t  i_sample,
  input wire logic                    i_mod_reset_evt,
  input wire iqso_pkg::iqso_pins_t    o_pins
);
  import iqso_pkg::*;
  logic [7:0] fmt_r;
  logic [3:0] div_r;
  logic       go;
  logic       ge;

  // Shadow registers; pin checks only hold at divisor 1, fixed cycles
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fmt_r <= `IQSO_FMT_RST;
      div_r <= `IQSO_DIV_RST;
    end else if (i_reg_wr && i_reg_addr == `IQSO_ADDR_FMT) begin
      fmt_r <= i_reg_wdata;
    end else if (i_reg_wr && i_reg_addr == `IQSO_ADDR_DIV) begin
      div_r <= i_reg_wdata[3:0];
    end
  end
  assign go = i_sample_stb && div_r == 4'h1 && !fmt_r[`IQSO_FMT_EFS];
  assign ge = i_sample_stb && div_r == 4'h1 && fmt_r[`IQSO_FMT_EFS];

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////////////////
  property p_reset_tri;
    $rose(i_rst_n) |-> o_pins.frame_sync_oe_n && o_pins.bit_clock_oe_n;
  endproperty
  a_reset_tri: assert property (p_reset_tri)
    else $error("sync or clock driven after reset");
  property p_fmt_read;
    i_reg_rd && i_reg_addr == `IQSO_ADDR_FMT |=> o_reg_rdata == $past(fmt_r);
  endproperty
  a_fmt_read: assert property (p_fmt_read)
    else $error("format register read mismatch");
  property p_sync_pulse;
    go && fmt_r[3:2] == 2'b00 |-> ##2 o_pins.frame_sync_out ##1 !o_pins.frame_sync_out;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse)
    else $error("sync pulse not one bit long");
  property p_sync_inv;
    go && fmt_r[3:2] == 2'b10 |-> ##2 !o_pins.frame_sync_out ##1 o_pins.frame_sync_out;
  endproperty
  a_sync_inv: assert property (p_sync_inv)
    else $error("inverted sync wrong");
  property p_late;
    go && fmt_r[3:2] == 2'b01 |->
      ##2 o_pins.frame_sync_out && o_pins.serial_data_out == $past(i_sample.i_word[23], 2);
  endproperty
  a_late: assert property (p_late)
    else $error("late sync not on first data bit");
  property p_first_bit;
    go && !fmt_r[2] |-> ##3 o_pins.serial_data_out == $past(i_sample.i_word[23], 3);
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first data bit not I msb");
  property p_efs_sync;
    ge |-> ##2 (!o_pins.frame_sync_out) [*8];
  endproperty
  a_efs_sync: assert property (p_efs_sync)
    else $error("sync pin not low in embedded framing");
  property p_start_bit;
    ge |-> ##2 !o_pins.serial_data_out
      ##1 o_pins.serial_data_out == $past(i_sample.i_word[23], 3);
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("start bit or first data bit wrong");
endmodule

bind iqso_port iqso_port_properties i_iqso_port_properties (.*);
`default_nettype wire

// ### iqso_host_rx.sv
/*
  Host serial port model: samples data on the falling bit clock.
  Assumes three-wire framing and a divisor of at least two.
*/
`timescale 1ns/100ps
`default_nettype none

module iqso_host_rx (
  // Serial link from the port
  input  wire logic        i_bclk,
  input  wire logic        i_fs,
  input  wire logic        i_data,
  // Received bits
  output var logic  [63:0] o_shift,
  output var int           o_nbits
);
  // Sync bit restarts the count; data shifts in MSB first
  always @(negedge i_bclk) begin
    if (i_fs) begin
      o_nbits <= 0;
    end else begin
      o_shift <= {o_shift[62:0], i_data};
      o_nbits <= o_nbits + 1;
    end
  end
endmodule
`default_nettype wire

// ### iqso_port_tb_top.sv
/*
  Testbench for iqso_port: registers, frame content and pin modes.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
`include "iqso_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: %h not %h", $time, g, e); end end

module iqso_port_tb_top;
  import iqso_pkg::*;
  logic         clock, rst_n, reg_wr, reg_rd, stb, evt, bclk;
  logic [5:0]   reg_addr;
  logic [7:0]   reg_wdata;
  logic [7:0]   rdata;
  iqso_sample_t smp;
  iqso_pins_t   pins;
  logic [63:0]  rx_shift;
  int           rx_nbits, fail_count, n_compared, cycles;

  // Released clock pin reads as pulled up
  assign bclk = pins.bit_clock_oe_n | pins.bit_clock_out;
  iqso_port i_iqso_port (.i_clock(clock), .i_rst_n(rst_n), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
    .i_sample_stb(stb), .i_sample(smp), .i_mod_reset_evt(evt), .o_pins(pins));
  iqso_host_rx i_iqso_host_rx (.i_bclk(bclk), .i_fs(pins.frame_sync_out),
    .i_data(pins.serial_data_out), .o_shift(rx_shift), .o_nbits(rx_nbits));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic send(input iqso_sample_t s);
    @(posedge clock);
    smp <= s;
    stb <= 1'b1;
    @(posedge clock);
    stb <= 1'b0;
  endtask
  // Bounded wait on the host bit count
  task automatic wait_bits(input int n);
    int k;
    k = 0;
    while (rx_nbits != n && k < 600) begin
      @(posedge clock);
      k++;
    end
    `CHK(rx_nbits, n)
  endtask
  task automatic t_regs();
    rd(`IQSO_ADDR_FMT, 8'h12);
    rd(`IQSO_ADDR_WIDTH, 8'h07);
    rd(`IQSO_ADDR_DIV, 8'h01);
    rd(6'h05, 8'h00);
    wr(`IQSO_ADDR_DIV, 8'hf2);
    rd(`IQSO_ADDR_DIV, 8'h02);
  endtask
  // g: 0 no gain, 1 both bytes, 2 attenuation turn, 3 status turn
  task automatic t_frame(input logic [7:0] fmt, input logic [7:0] wid, input logic [3:0] div,
                         input logic [1:0] g, input logic [1:0] rc, input int n,
                         input logic abort);
    iqso_sample_t s;
    logic [63:0]  e;
    s = {24'h9a3c5e ^ {3{fmt}}, 24'h2b4d6f ^ {3{wid}}, 8'hb6 ^ fmt, 6'h2d};
    e = wid[3] ? {16'h0, s.i_word, s.q_word} : {32'h0, s.i_word[23:8], s.q_word[23:8]};
    if (g == 2'd1) e = {e[47:0], s.atten, rc, s.rssi};
    if (g == 2'd2) e = {e[55:0], s.atten[7:1], 1'b0};
    if (g == 2'd3) e = {e[55:0], rc, s.rssi[5:1], 1'b1};
    wr(`IQSO_ADDR_WIDTH, wid);
    wr(`IQSO_ADDR_DIV, {4'h0, div});
    wr(`IQSO_ADDR_FMT, fmt);
    repeat (g == 2'd3 ? 5 : 0) begin
      @(posedge clock);
      evt <= 1'b1;
      @(posedge clock);
      evt <= 1'b0;
    end
    if (abort) begin
      send(~s);
      repeat (20) @(posedge clock);
    end
    send(s);
    wait_bits(0);
    wait_bits(n);
    `CHK(rx_shift << (64 - n), e << (64 - n))
    wait_bits(n + 8);
    `CHK(rx_shift[7:0], 8'hff)
  endtask
  task automatic t_sync();
    logic [7:0] f [8] = '{8'h00, 8'h04, 8'h08, 8'h02, 8'h01, 8'h20, 8'h24, 8'h30};
    wr(`IQSO_ADDR_WIDTH, 8'h07);
    wr(`IQSO_ADDR_DIV, 8'h01);
    foreach (f[k]) begin
      wr(`IQSO_ADDR_FMT, f[k]);
      send({24'hc3a50f, 24'h5a0ff0, 8'h81, 6'h15});
      repeat (60) @(posedge clock);
      `CHK(pins.serial_data_out, 1'b1)
      `CHK(pins.frame_sync_oe_n, f[k][4])
      `CHK(pins.bit_clock_oe_n, f[k][1])
      `CHK(pins.bit_clock_out, ~f[k][0])
    end
  endtask
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    stb = 1'b0;
    evt = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    smp = '0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_frame(8'h00, 8'h07, 4'h2, 2'd0, 2'd0, 32, 1'b1);
    t_frame(8'hc0, 8'h07, 4'h2, 2'd2, 2'd0, 40, 1'b0);
    t_frame(8'hc0, 8'h0f, 4'h2, 2'd3, 2'd3, 56, 1'b0);
    // Strobes come only by hand, so every frame but the aborted one fits its divisor
    t_frame(8'h40, 8'h0f, 4'h3, 2'd1, 2'd0, 64, 1'b0);
    t_sync();
    conclude();
  end
endmodule
`default_nettype wire
